// ==== rtl/adc_ctrl_pkg.sv ====
/*
 * constants for the converter control block: pin indices, state codes,
 * timing figures and the cycle counts derived from them.
 * assumes a 250 MHz system clock; imported by the control module, not by the word buffer.
 */
// Function
// - chip select low wakes device, drives data
// - sleep after conversion while select high
// - select rising mid-transfer aborts, restarts conversion
// - data pin high impedance while select high
// - output phase shifts result bits out
// - status shown on data pin otherwise
// - internal mode drives shift clock out
// - external mode takes host shift clock
// - pull-up enabled in internal clock mode
// - clock mode latched at reset, select fall
// - frequency pin high gives 50Hz null
// - frequency pin low gives 60Hz null
// - external clock on frequency pin drives conversion
// - data changes on falling shift edges
// - 24 bits end output, new conversion
// - early select rise returns to sleep
`default_nettype none
package adc_ctrl_pkg;

	// ----------------------------------------------------------------
	// clock and pins
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned CLK_HZ        = 250_000_000;
	localparam int unsigned PIN_CS        = 0;
	localparam int unsigned PIN_SCK       = 1;
	localparam int unsigned PIN_FREQ      = 2;
	localparam int unsigned NUM_PINS      = 3;
	localparam logic [2:0]  PIN_RESET_LVL = 3'h7; // select idle high, floating pins high

	// ----------------------------------------------------------------
	// data word
	// ----------------------------------------------------------------
	localparam int unsigned WORD_BITS      = 24;
	localparam logic [4:0]  LAST_BIT_INDEX = 5'h17;
	localparam int unsigned BUF_DEPTH      = 2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CONV_TIME_60_US   = 66900;
	localparam int unsigned CONV_TIME_50_US   = 80300;
	localparam int unsigned CONV_60_CYCLES_DEF = CONV_TIME_60_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned CONV_50_CYCLES_DEF = CONV_TIME_50_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned CONV_EXT_PERIODS  = 10278;  // conversion length in external clock periods
	localparam int unsigned FILTER_NULL_DIV   = 2560;   // first null = external clock / this
	localparam int unsigned SCK_FREQ_HZ       = 19200;
	localparam int unsigned SCK_HALF_DEF      = CLK_HZ / (2 * SCK_FREQ_HZ);
	localparam int unsigned EXT_OSC_MIN_HZ    = 5000;
	localparam int unsigned EXT_DETECT_DEF    = 2 * (CLK_HZ / EXT_OSC_MIN_HZ);
	localparam logic [2:0]  POR_SAMPLE_CYCLES = 3'h6; // strap taken once the filtered level has settled

	// ----------------------------------------------------------------
	// converter cycle states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_CONV  = 3'h1,
		ST_SLEEP = 3'h2,
		ST_OUT   = 3'h4
	} conv_state_t;

endpackage
`default_nettype wire

// ==== rtl/adc_serial_output_control.sv ====
/*
 * converter cycle control and 3-wire serial output: conversion, sleep,
 * data output, status on the data pin, clock-mode latch and oscillator /
 * notch selection from the frequency pin.
 * assumes conversion words arrive from the modulator side on adc_word
 * and that the pad ring resolves pins from the output enables.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_serial_output_control
	import adc_ctrl_pkg::*;
#(
	parameter int unsigned CONV_60_CYCLES = CONV_60_CYCLES_DEF,
	parameter int unsigned CONV_50_CYCLES = CONV_50_CYCLES_DEF,
	parameter int unsigned SCK_HALF       = SCK_HALF_DEF,
	parameter int unsigned EXT_DETECT     = EXT_DETECT_DEF
)
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 cs_n,
	input  wire logic                 sck_in,
	output logic                      sck_out,
	output logic                      sck_oe_n,
	output logic                      sck_pullup_en,
	output logic                      sdo_out,
	output logic                      sdo_oe_n,
	input  wire logic                 freq_select_pin,
	input  wire logic [WORD_BITS-1:0] adc_word,
	input  wire logic                 adc_word_valid,
	output logic                      adc_word_ready,
	output logic                      low_power,
	output logic                      ext_osc_active,
	output logic                      notch_50hz
);
	logic [NUM_PINS-1:0]  sync1_reg;
	logic [NUM_PINS-1:0]  sync2_reg;
	logic [NUM_PINS-1:0]  sync3_reg;
	logic [NUM_PINS-1:0]  lvl_reg;
	logic [NUM_PINS-1:0]  chg;
	conv_state_t          state_reg;
	logic [31:0]          conv_cnt_reg;
	logic [31:0]          conv_load;
	logic [31:0]          ext_idle_reg;
	logic [31:0]          half_cnt_reg;
	logic [WORD_BITS-1:0] shift_reg;
	logic [WORD_BITS-1:0] buf_data;
	logic [4:0]           rise_cnt_reg;
	logic [2:0]           por_cnt_reg;
	logic                 started_reg;
	logic                 int_mode_reg;
	logic                 sck_out_reg;
	logic                 sck_oe_n_reg;
	logic                 pullup_reg;
	logic                 sdo_out_reg;
	logic                 sdo_oe_n_reg;
	logic                 sleep_reg;
	logic                 ext_osc_reg;
	logic                 notch_50_reg;
	logic                 buf_valid;
	logic                 pop;
	logic                 cs_hi;
	logic                 cs_fall;
	logic                 freq_rise;
	logic                 tick;
	logic                 rise_evt;
	logic                 fall_evt;
	logic                 conv_tick;

	// ----------------------------------------------------------------
	// pin synchronisers: three stages, change taken when 2nd and 3rd agree
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++)
		begin : g_sync
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					sync1_reg[gi] <= PIN_RESET_LVL[gi];
					sync2_reg[gi] <= PIN_RESET_LVL[gi];
					sync3_reg[gi] <= PIN_RESET_LVL[gi];
					lvl_reg[gi]   <= PIN_RESET_LVL[gi];
				end
				else
				begin
					sync1_reg[gi] <= gi == PIN_CS ? cs_n : (gi == PIN_SCK ? sck_in : freq_select_pin);
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
					if (chg[gi])
						lvl_reg[gi] <= sync3_reg[gi];
				end
			end
			assign chg[gi] = (sync2_reg[gi] == sync3_reg[gi]) && (sync3_reg[gi] != lvl_reg[gi]);
		end
	endgenerate

	assign cs_hi     = lvl_reg[PIN_CS];
	assign cs_fall   = chg[PIN_CS] & ~sync3_reg[PIN_CS];
	assign freq_rise = chg[PIN_FREQ] & sync3_reg[PIN_FREQ];

	// ----------------------------------------------------------------
	// result buffer: stall by the output side back-pressures the source
	// ----------------------------------------------------------------
	assign pop = (state_reg == ST_CONV) && (conv_cnt_reg == '0);

	word_buffer2 #(.W(WORD_BITS), .DEPTH(BUF_DEPTH)) u_buf (
		.clk       (clk),
		.rst       (rst),
		.in_data   (adc_word),
		.in_valid  (adc_word_valid),
		.in_ready  (adc_word_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (pop)
	);

	// ----------------------------------------------------------------
	// oscillator detection: edges on the frequency pin mean external clock
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ext_idle_reg <= '0;
		else if (chg[PIN_FREQ] && por_cnt_reg == '0) // filter settling from its reset level is no clock edge
			ext_idle_reg <= EXT_DETECT;
		else if (ext_idle_reg != '0)
			ext_idle_reg <= ext_idle_reg - 32'h1;
	end

	// conversion length follows oscillator and notch choice
	assign conv_load = ext_osc_reg ? CONV_EXT_PERIODS : (lvl_reg[PIN_FREQ] ? CONV_50_CYCLES : CONV_60_CYCLES);
	assign conv_tick = ext_osc_reg ? freq_rise : 1'b1;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			conv_cnt_reg <= CONV_60_CYCLES;
		else if (state_reg != ST_CONV)
			conv_cnt_reg <= conv_load;
		else if (conv_tick && conv_cnt_reg != '0)
			conv_cnt_reg <= conv_cnt_reg - 32'h1;
	end

	// ----------------------------------------------------------------
	// clock-mode latch: sampled after reset and at each select fall
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			por_cnt_reg  <= POR_SAMPLE_CYCLES;
			int_mode_reg <= 1'b1;
		end
		else
		begin
			if (por_cnt_reg != '0)
				por_cnt_reg <= por_cnt_reg - 3'h1;
			if (por_cnt_reg == 3'h1 || cs_fall)
				int_mode_reg <= lvl_reg[PIN_SCK]; // low = external, high/floating = internal
		end
	end

	// ----------------------------------------------------------------
	// shift clock events; internal mode generates its own
	// ----------------------------------------------------------------
	assign tick     = (state_reg == ST_OUT) && int_mode_reg && (half_cnt_reg == '0);
	assign rise_evt = int_mode_reg ? (tick & ~sck_out_reg) : (chg[PIN_SCK] & sync3_reg[PIN_SCK]);
	assign fall_evt = int_mode_reg ? (tick & sck_out_reg) : (chg[PIN_SCK] & ~sync3_reg[PIN_SCK]);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			half_cnt_reg <= '0;
			sck_out_reg  <= 1'b0;
		end
		else if ((state_reg == ST_OUT) && int_mode_reg && !cs_hi)
		begin
			half_cnt_reg <= (half_cnt_reg == '0) ? SCK_HALF - 1 : half_cnt_reg - 32'h1;
			if (tick)
				sck_out_reg <= ~sck_out_reg;
		end
		else
		begin
			half_cnt_reg <= SCK_HALF - 1;
			sck_out_reg  <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// converter cycle: conversion, sleep, data output
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_reg <= ST_CONV;
		else
		begin
			case (state_reg)
				ST_CONV:
				begin
					if (pop && buf_valid)
						state_reg <= ST_SLEEP;
				end
				ST_SLEEP:
				begin
					if (!cs_hi)
						state_reg <= ST_OUT;
				end
				ST_OUT:
				begin
					if (cs_hi)
						state_reg <= started_reg ? ST_CONV : ST_SLEEP;
					else if (rise_evt && rise_cnt_reg == LAST_BIT_INDEX)
						state_reg <= ST_CONV;
				end
				default:
					state_reg <= ST_CONV;
			endcase
		end
	end

	// bit bookkeeping; result held until first rising edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			started_reg  <= 1'b0;
			rise_cnt_reg <= '0;
			shift_reg    <= '0;
		end
		else
		begin
			if (state_reg != ST_OUT)
			begin
				started_reg  <= 1'b0;
				rise_cnt_reg <= '0;
			end
			else if (rise_evt && !cs_hi)
			begin
				started_reg  <= 1'b1;
				rise_cnt_reg <= rise_cnt_reg + 5'h1;
			end
			if (pop && buf_valid)
				shift_reg <= buf_data;
			else if (state_reg == ST_OUT && started_reg && fall_evt && !cs_hi)
				shift_reg <= {shift_reg[WORD_BITS-2:0], 1'b0}; // next bit on falling edge
		end
	end

	// ----------------------------------------------------------------
	// registered pin drivers and status outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sdo_out_reg  <= 1'b1;
			sdo_oe_n_reg <= 1'b1;
			sck_oe_n_reg <= 1'b1;
			pullup_reg   <= 1'b1;
			sleep_reg    <= 1'b0;
			ext_osc_reg  <= 1'b0;
			notch_50_reg <= 1'b1;
		end
		else
		begin
			sdo_oe_n_reg <= cs_hi;
			// busy high while converting, low when a result waits
			sdo_out_reg  <= (state_reg == ST_OUT) ? shift_reg[WORD_BITS-1] : (state_reg == ST_CONV);
			sck_oe_n_reg <= !((state_reg == ST_OUT) && int_mode_reg);
			pullup_reg   <= int_mode_reg;
			sleep_reg    <= (state_reg == ST_SLEEP) && cs_hi;
			ext_osc_reg  <= (ext_idle_reg != '0);
			notch_50_reg <= (ext_idle_reg == '0) && lvl_reg[PIN_FREQ];
		end
	end

	assign sck_out        = sck_out_reg;
	assign sck_oe_n       = sck_oe_n_reg;
	assign sck_pullup_en  = pullup_reg;
	assign sdo_out        = sdo_out_reg;
	assign sdo_oe_n       = sdo_oe_n_reg;
	assign low_power      = sleep_reg;
	assign ext_osc_active = ext_osc_reg;
	assign notch_50hz     = notch_50_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_out_started;
		state_reg == ST_OUT && started_reg;
	endsequence
	sequence s_out_idle;
		state_reg == ST_OUT && !started_reg;
	endsequence

	AST_WAKE: assert property (state_reg == ST_SLEEP && !cs_hi |=> state_reg == ST_OUT)
		else $error("select low did not wake");
	AST_SLEEP: assert property (state_reg == ST_CONV && pop && buf_valid |=> state_reg == ST_SLEEP)
		else $error("no sleep after conversion");
	AST_SLEEP_HOLD: assert property (state_reg == ST_SLEEP && cs_hi |=> state_reg == ST_SLEEP)
		else $error("sleep left while deselected");
	AST_ABORT: assert property (s_out_started ##0 cs_hi |=> state_reg == ST_CONV)
		else $error("abort did not restart conversion");
	AST_HIZ: assert property (cs_hi |=> sdo_oe_n_reg)
		else $error("data pin driven while deselected");
	AST_SHIFT: assert property (s_out_started ##0 (fall_evt && !cs_hi && !pop)
		|=> shift_reg == {$past(shift_reg[WORD_BITS-2:0]), 1'b0} ##1 sdo_out_reg == shift_reg[WORD_BITS-1])
		else $error("bit not shifted on falling edge");
	AST_STATUS: assert property (state_reg == ST_CONV |=> sdo_out_reg)
		else $error("status not high during conversion");
	AST_STATUS_RDY: assert property (state_reg == ST_SLEEP |=> !sdo_out_reg)
		else $error("status not low when ready");
	AST_SCK_DRV: assert property (state_reg == ST_OUT && int_mode_reg |=> !sck_oe_n_reg)
		else $error("internal shift clock not driven");
	AST_SCK_IN: assert property (!int_mode_reg |=> sck_oe_n_reg)
		else $error("shift clock driven in external mode");
	AST_PULLUP: assert property (int_mode_reg |=> pullup_reg)
		else $error("pull-up off in internal mode");
	AST_MODE: assert property (cs_fall && por_cnt_reg == '0 |=> int_mode_reg == $past(lvl_reg[PIN_SCK]))
		else $error("clock mode not latched on select fall");
	AST_NOTCH: assert property (ext_idle_reg == '0 ##1 ext_idle_reg == '0 |-> notch_50_reg == $past(lvl_reg[PIN_FREQ]))
		else $error("notch select wrong");
	AST_EXT: assert property (chg[PIN_FREQ] && por_cnt_reg == '0 |=> ##1 ext_osc_reg)
		else $error("external clock not detected");
	AST_END24: assert property (state_reg == ST_OUT && !cs_hi && rise_evt && rise_cnt_reg == LAST_BIT_INDEX
		|=> state_reg == ST_CONV)
		else $error("no conversion after 24 bits");
	AST_KEEP: assert property (s_out_idle ##0 cs_hi |=> state_reg == ST_SLEEP && $stable(shift_reg))
		else $error("early deselect lost result");
endmodule
`default_nettype wire

// ==== rtl/word_buffer2.sv ====
/*
 * two-entry word buffer with valid/ready on both sides.
 * assumes one clock; in_ready is a flip-flop so it may leave the block.
 */
`timescale 1ns/1ps
`default_nettype none
module word_buffer2
#(
	parameter int unsigned W     = 24,
	parameter int unsigned DEPTH = 2
)
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [W-1:0]  mem [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0]   count_reg;
	logic [PW:0]   count_next;
	logic          in_ready_reg;
	logic          push;
	logic          pop;

	// ----------------------------------------------------------------
	// handshakes
	// ----------------------------------------------------------------
	assign push      = in_valid & in_ready_reg;
	assign pop       = out_valid & out_ready;
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];
	assign in_ready  = in_ready_reg;

	always_comb
	begin
		count_next = count_reg;
		if (push & ~pop)
			count_next = count_reg + (PW+1)'(1);
		else if (pop & ~push)
			count_next = count_reg - (PW+1)'(1);
	end

	// storage; no reset on data, only on pointers, count and ready
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// pointers and occupancy; ready is registered from next count
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg   <= '0;
			rd_ptr_reg   <= '0;
			count_reg    <= '0;
			in_ready_reg <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + PW'(1);
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + PW'(1);
			count_reg    <= count_next;
			in_ready_reg <= (count_next < (PW+1)'(DEPTH));
		end
	end
endmodule
`default_nettype wire

// ==== tb/adc_serial_output_control_tb_top.sv ====
/*
 * self-checking bench for the converter control block and its serial port.
 * assumes short conversion and shift counts set through the parameters.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_serial_output_control_tb_top import adc_ctrl_pkg::*;;
	localparam int C60 = 200;
	localparam int C50 = 240;

	logic        clk;
	logic        rst;
	logic        freq_pin;
	logic [23:0] adc_word;
	logic        adc_word_valid;
	int          n_in;
	logic        cs_n;
	logic        sck_drv;
	logic        sck_pin;
	logic        sdo_pin;
	logic        sdo_last;
	logic        saw_sck;
	logic        sck_out;
	logic        sck_oe_n;
	logic        sck_pullup_en;
	logic        sdo_out;
	logic        sdo_oe_n;
	logic        adc_word_ready;
	logic        low_power;
	logic        ext_osc_active;
	logic        notch_50hz;
	int          n_fail;
	int          samples_checked;

	function automatic logic [23:0] word_of(input int i);
		return 24'hA5C300 ^ {i[7:0], ~i[7:0], i[7:0]};
	endfunction

	adc_serial_output_control #(.CONV_60_CYCLES(C60), .CONV_50_CYCLES(C50), .SCK_HALF(4), .EXT_DETECT(40)) uut
	(
		.clk             (clk),
		.rst             (rst),
		.cs_n            (cs_n),
		.sck_in          (sck_pin),
		.sck_out         (sck_out),
		.sck_oe_n        (sck_oe_n),
		.sck_pullup_en   (sck_pullup_en),
		.sdo_out         (sdo_out),
		.sdo_oe_n        (sdo_oe_n),
		.freq_select_pin (freq_pin),
		.adc_word        (adc_word),
		.adc_word_valid  (adc_word_valid),
		.adc_word_ready  (adc_word_ready),
		.low_power       (low_power),
		.ext_osc_active  (ext_osc_active),
		.notch_50hz      (notch_50hz)
	);

	host_model host
	(
		.clk     (clk),
		.sck_pin (sck_pin),
		.sdo_pin (sdo_pin),
		.cs_n    (cs_n),
		.sck_drv (sck_drv)
	);

	// ------------------------------------------------------------
	// pins: a released sdo shows the inverse of its last level
	// ------------------------------------------------------------
	assign sck_pin = sck_oe_n ? sck_drv : sck_out;
	assign sdo_pin = sdo_oe_n ? ~sdo_last : sdo_out;

	always @(posedge clk)
	begin
		if (sdo_oe_n === 1'b0)
			sdo_last <= sdo_out;
		if (sck_oe_n === 1'b0)
			saw_sck <= 1'b1;
		if (adc_word_valid && adc_word_ready)
		begin
			n_in <= n_in + 1;
			adc_word <= word_of(n_in + 1);
		end
	end

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ------------------------------------------------------------
	// compare and wait helpers
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_rng(input string name, input int lo, input int hi, input int got);
		samples_checked++;
		if (got < lo || got > hi)
		begin
			n_fail++;
			$display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	// bounded wait for sleep; an overrun shows up in the range check
	task automatic wait_sleep(output int n);
		n = 0;
		while (low_power !== 1'b1 && n < 1000)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic summarize();
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset_fill();
		repeat (10) @(posedge clk);
		chk("sdo_oe_n", 24'h1, sdo_oe_n);
		chk("pullup", 24'h0, sck_pullup_en);
		chk("notch_50hz", 24'h0, notch_50hz);
		chk("word_ready", 24'h0, adc_word_ready);
		chk("words_taken", 24'h2, n_in[23:0]);
	endtask

	task automatic t_status();
		host.select(1'b0);
		repeat (10) @(posedge clk);
		chk("sdo_oe_n", 24'h0, sdo_oe_n);
		chk("status", 24'h1, sdo_pin);
		chk("low_power", 24'h0, low_power);
		host.select(1'b1);
		repeat (10) @(posedge clk);
		chk("sdo_oe_n", 24'h1, sdo_oe_n);
	endtask

	task automatic t_sleep();
		int n;
		wait_sleep(n);
		chk_rng("first_conv", 1, C60, n);
		chk("status", 24'h0, sdo_out);
		repeat (40) @(posedge clk);
		chk("low_power", 24'h1, low_power);
	endtask

	task automatic t_ext_full(input int idx, input int conv);
		logic [23:0] w;
		logic        ok;
		int          n;
		saw_sck <= 1'b0;
		host.ext_read(24, w, ok);
		chk("word", word_of(idx), w);
		chk("hold", 24'h1, ok);
		chk("sck_driven", 24'h0, saw_sck);
		chk("pullup", 24'h0, sck_pullup_en);
		wait_sleep(n);
		chk_rng("conv_len", conv - 24, conv + 4, n);
	endtask

	task automatic t_early();
		host.select(1'b0);
		repeat (12) @(posedge clk);
		chk("sdo_oe_n", 24'h0, sdo_oe_n);
		host.select(1'b1);
		repeat (12) @(posedge clk);
		chk("low_power", 24'h1, low_power);
	endtask

	task automatic t_abort();
		logic [23:0] w;
		logic [23:0] e;
		logic        ok;
		int          n;
		e = word_of(2);
		host.ext_read(8, w, ok);
		chk("part_word", {16'h0, e[23:16]}, {16'h0, w[7:0]});
		repeat (12) @(posedge clk);
		chk("low_power", 24'h0, low_power);
		wait_sleep(n);
		chk_rng("abort_conv", C60 - 4, C60 + 16, n);
	endtask

	task automatic t_internal();
		logic [23:0] w;
		int          n;
		saw_sck <= 1'b0;
		host.int_read(w);
		chk("word", word_of(3), w);
		chk("sck_driven", 24'h1, saw_sck);
		chk("pullup", 24'h1, sck_pullup_en);
		wait_sleep(n);
		chk_rng("int_conv", C60 - 24, C60 + 4, n);
	endtask

	// word input held off across a pop: nothing may be taken while valid is low
	task automatic t_refuse();
		int k;
		@(posedge clk);
		adc_word_valid <= 1'b0;
		k = n_in;
		t_internal();
		chk("words_held", k[23:0], n_in[23:0]);
		chk("word_ready", 24'h1, adc_word_ready);
		@(posedge clk);
		adc_word_valid <= 1'b1;
		repeat (4) @(posedge clk);
		chk("words_taken", k[23:0] + 24'h1, n_in[23:0]);
		chk("word_ready", 24'h0, adc_word_ready);
	endtask

	task automatic t_freq();
		@(posedge clk);
		freq_pin <= 1'b1;
		repeat (50) @(posedge clk); // a lone level change reads as a clock for a while
		chk("notch_50hz", 24'h1, notch_50hz);
		t_ext_full(4, C50);
		freq_pin <= 1'b0;
		repeat (50) @(posedge clk);
		chk("notch_50hz", 24'h0, notch_50hz);
	endtask

	task automatic t_extosc();
		for (int i = 0; i < 24; i++)
		begin
			repeat (10) @(posedge clk);
			freq_pin <= ~freq_pin;
		end
		chk("ext_osc", 24'h1, ext_osc_active);
		chk("notch_50hz", 24'h0, notch_50hz);
		repeat (60) @(posedge clk);
		chk("ext_osc", 24'h0, ext_osc_active);
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		freq_pin = 1'b0;
		adc_word = word_of(0);
		adc_word_valid = 1'b1;
		n_in = 0;
		sdo_last = 1'b0;
		saw_sck = 1'b0;
		n_fail = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset_fill();
		t_status();
		t_sleep();
		t_ext_full(0, C60);
		t_early();
		t_ext_full(1, C60);
		t_abort();
		t_refuse();
		t_freq();
		t_extosc();
		summarize();
	end

	// a hang costs far more than the ~3300 cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		summarize();
	end

endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
/*
 * host side model: drives chip select and the shift clock, captures data.
 * assumes the bench resolves the sck and sdo pins and feeds them back here.
 */
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input  wire logic clk,
	input  wire logic sck_pin,
	input  wire logic sdo_pin,
	output var logic  cs_n,
	output var logic  sck_drv
);
	// half period well above the ~4 clk pin filter of the device
	localparam int HALF = 8;

	// idle: deselected, strap low for external shift clock
	initial
	begin
		cs_n = 1'b1;
		sck_drv = 1'b0;
	end

	// ------------------------------------------------------------
	// plain select moves
	// ------------------------------------------------------------
	task automatic select(input logic lvl);
		@(posedge clk);
		cs_n <= lvl;
	endtask

	// ------------------------------------------------------------
	// external clock read; a short count ends as an abort
	// ------------------------------------------------------------
	task automatic ext_read(input int nbits, output logic [23:0] w, output logic ok);
		w = 24'h0;
		ok = 1'b1;
		@(posedge clk);
		sck_drv <= 1'b0;
		cs_n <= 1'b0;
		repeat (HALF) @(posedge clk);
		for (int i = 0; i < nbits; i++)
		begin
			sck_drv <= 1'b1;
			w = {w[22:0], sdo_pin};
			repeat (HALF) @(posedge clk);
			// after the last bit the pin shows status again, so skip it
			if (i < 23)
				ok = ok & (sdo_pin === w[0]);
			sck_drv <= 1'b0;
			repeat (HALF) @(posedge clk);
		end
		cs_n <= 1'b1;
	endtask

	// ------------------------------------------------------------
	// internal clock read: strap high, count rising edges on the pin
	// ------------------------------------------------------------
	task automatic int_read(output logic [23:0] w);
		logic prev;
		int   n;
		int   guard;
		w = 24'h0;
		prev = 1'b1;
		n = 0;
		guard = 0;
		@(posedge clk);
		sck_drv <= 1'b1;
		repeat (HALF) @(posedge clk);
		cs_n <= 1'b0;
		while (n < 24 && guard < 2000)
		begin
			@(posedge clk);
			if (sck_pin && !prev)
			begin
				w = {w[22:0], sdo_pin};
				n++;
			end
			prev = sck_pin;
			guard++;
		end
		repeat (HALF) @(posedge clk);
		cs_n <= 1'b1;
		sck_drv <= 1'b0;
	endtask

endmodule
`default_nettype wire
